// ===== hw/mcei_pkg.sv
/*
 * Constants for the metering compute engine interface: host byte map of
 * the engine data memory, frame timing, accumulation and element mapping.
 * Assumes a 100 MHz core clock and a one-cycle 32768 Hz time base tick.
 */
// Functional notes
// - Each engine data word is four bytes holding a 32-bit two's complement value.
// - Word MSB sits at byte 0x0000+4*word, LSB at byte 0x0003+4*word.
// - A mux frame is 13 time base cycles; conversions use 12, one settles.
// - Accumulation count is presample multiplier times cycle count; interval is count/rate.
// - Chop control 00 runs auto chopping and periodic alternate mux sequence.
// - Equation select maps voltage and current products onto elements 0 and 1.
// - A current gain is 8 with its shunt select set, else 1.
// - Undervoltage threshold LSB is full-scale voltage times 7.8798 millionths.
// - Equation select 0 runs a different code variant than selects 1 and 2.
package mcei_pkg;
   localparam int            WORD_BYTES       = 4;
   localparam int            WORD_W           = 32;
   localparam int            MEM_WORDS        = 64;
   localparam int            ADDR_W           = 8;
   localparam int            WIDX_W           = 6;
   localparam logic [1:0]    MSB_LANE         = 2'h0;
   localparam int            BASE_HZ          = 32768;
   localparam logic [3:0]    FRAME_LAST       = 4'hc;
   localparam logic [3:0]    CONV_BUDGET      = 4'hc;
   localparam int            SAMPLE_W         = 16;
   localparam int            CUR_W            = 20;
   localparam int            ACC_W            = 48;
   localparam int            ACC_LSB          = 16;
   localparam int            ACCUMULATION_COUNT_W           = 13;
   localparam logic [2:0]    SHUNT_SHIFT      = 3'h3;
   localparam logic [6:0]    PRE_MULT0        = 7'h2a;
   localparam logic [6:0]    PRE_MULT1        = 7'h32;
   localparam logic [6:0]    PRE_MULT2        = 7'h54;
   localparam logic [6:0]    PRE_MULT3        = 7'h64;
   localparam logic [3:0]    ALT_PERIOD       = 4'hf;
   localparam logic [2:0]    EQU_TWO_WIRE     = 3'h0;
   localparam logic [2:0]    EQU_SPLIT        = 3'h1;
   localparam logic [2:0]    EQU_TWO_ELEM     = 3'h2;
   localparam logic [1:0]    CHOP_AUTO        = 2'h0;
   localparam logic [WIDX_W-1:0] W0_WORD      = 6'h10;
   localparam logic [WIDX_W-1:0] W1_WORD      = 6'h11;
   localparam logic [WIDX_W-1:0] I0SQ_WORD    = 6'h12;
   localparam logic [WIDX_W-1:0] I1SQ_WORD    = 6'h13;
   localparam logic [WIDX_W-1:0] STATUS_WORD  = 6'h14;
   localparam logic [WIDX_W-1:0] UNDERVOLTAGE_THRESHOLD_WORD = 6'h15;
   localparam int            STATUS_SAG_BIT   = 25;
   localparam real           SAG_LSB_PER_FULL_SCALE_VOLTAGE = 7.8798e-6;
   localparam real           FS_HZ            = BASE_HZ / 13.0;
endpackage

// ===== hw/mcei_engine.sv
/*
 * Metering compute engine interface: byte-wide host access to the engine
 * data memory, mux frame sequencer on the 32768 Hz tick, element mapping
 * and energy accumulation. Assumes samples are valid at each frame end and
 * that the host holds configuration steady while the engine is enabled.
 */
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module mcei_engine (
   // Clock and reset
   input  wire logic                         i_clock,
   input  wire logic                         i_rst_b,
   // Host byte port
   input  wire logic [mcei_pkg::ADDR_W-1:0]  i_addr,
   input  wire logic [7:0]                   i_wdata,
   input  wire logic                         i_wr,
   input  wire logic                         i_rd,
   output logic      [7:0]                   o_rdata,
   // Configuration
   input  wire logic                         i_engine_enable,
   input  wire logic [2:0]                   i_meter_equation_select,
   input  wire logic [1:0]                   i_presample_multiplier,
   input  wire logic [5:0]                   i_accumulation_cycle_count,
   input  wire logic [3:0]                   i_conversions_per_frame,
   input  wire logic [15:0]                  i_slot_input_select,
   input  wire logic [15:0]                  i_slot_alternate_select,
   input  wire logic [1:0]                   i_chop_control,
   input  wire logic                         i_shunt_a,
   input  wire logic                         i_shunt_b,
   // Converter side
   input  wire logic                         i_tick_32k,
   input  wire logic [mcei_pkg::SAMPLE_W-1:0] i_va,
   input  wire logic [mcei_pkg::SAMPLE_W-1:0] i_vb,
   input  wire logic [mcei_pkg::SAMPLE_W-1:0] i_ia,
   input  wire logic [mcei_pkg::SAMPLE_W-1:0] i_ib,
   output logic      [3:0]                   o_mux_select,
   output logic                              o_chop,
   output logic                              o_frame_start,
   // Engine status
   output logic                              o_code_variant,
   output logic                              o_pass_done,
   output logic                              o_sag
);
   import mcei_pkg::*;

   logic [WORD_W-1:0]      mem_q [MEM_WORDS];
   logic [WIDX_W-1:0]      widx;
   logic [1:0]             lane;
   logic [WORD_W-1:0]      rword;
   logic [7:0]             rdata_d, rdata_q;
   logic [ACC_W-1:0]       acc_q [4];
   logic [ACC_W-1:0]       acc_d [4];
   logic [WORD_W-1:0]      res_q [4];
   logic [WORD_W-1:0]      res_d [4];
   logic [3:0]             fcyc_d, fcyc_q, cpc;
   logic [3:0]             altcnt_d, altcnt_q;
   logic                   chop_d, chop_q, alt_d, alt_q;
   logic [3:0]             mux_d, mux_q;
   logic [ACCUMULATION_COUNT_W-1:0]      accumulation_count, ncnt_d, ncnt_q;
   logic [6:0]             pre_mult;
   logic                   done_d, done_q, fstart_d, fstart_q, sag_d, sag_q, frame_end;
   logic signed [CUR_W-1:0] ia_g, ib_g, i0, i1;
   logic signed [SAMPLE_W-1:0] v1;
   logic signed [ACC_W-1:0] e0, e1, q0, q1;
   logic [SAMPLE_W-1:0]    va_mag;

   // Byte address split into word and lane
   assign widx = i_addr[ADDR_W-1:2];
   assign lane = i_addr[1:0];

   // Host byte writes; result words are engine-owned, so writes there are dropped
   always_ff @(posedge i_clock) begin
      if (i_wr && widx != W0_WORD && widx != W1_WORD && widx != I0SQ_WORD
          && widx != I1SQ_WORD && widx != STATUS_WORD) begin
         mem_q[widx][WORD_W-1-8*lane -: 8] <= i_wdata;
      end
   end

   // Read word select, then byte lane, registered one cycle
   always_comb begin
      case (widx)
         W0_WORD:     rword = res_q[0];
         W1_WORD:     rword = res_q[1];
         I0SQ_WORD:   rword = res_q[2];
         I1SQ_WORD:   rword = res_q[3];
         STATUS_WORD: rword = WORD_W'(sag_q) << STATUS_SAG_BIT;
         default:     rword = mem_q[widx];
      endcase
      rdata_d = i_rd ? rword[WORD_W-1-8*lane -: 8] : 8'h00;
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end
   assign o_rdata = rdata_q;

   // Cycles per conversion so that product with conversions is 12
   always_comb begin
      case (i_conversions_per_frame)
         4'h1:    cpc = CONV_BUDGET;
         4'h2:    cpc = 4'h6;
         4'h3:    cpc = 4'h4;
         4'h4:    cpc = 4'h3;
         4'h6:    cpc = 4'h2;
         4'hc:    cpc = 4'h1;
         default: cpc = 4'h3; // Unsupported counts fall back to four conversions
      endcase
   end

   // Frame sequencer: slot, chop and alternate sequence
   always_comb begin
      fcyc_d   = fcyc_q;
      altcnt_d = altcnt_q;
      chop_d   = chop_q;
      alt_d    = alt_q;
      mux_d    = mux_q;
      fstart_d = 1'b0;
      frame_end = i_tick_32k && fcyc_q == FRAME_LAST;
      if (frame_end) begin
         altcnt_d = altcnt_q + 4'h1;
         // Auto chop and periodic alternate frame
         if (i_chop_control == CHOP_AUTO) begin
            chop_d = ~chop_q;
            alt_d  = altcnt_q == ALT_PERIOD;
         end else begin
            chop_d = i_chop_control[1];
            alt_d  = 1'b0;
         end
      end
      if (i_tick_32k) begin
         // Thirteen ticks per frame, last one settles
         fcyc_d = (fcyc_q == FRAME_LAST) ? 4'h0 : fcyc_q + 4'h1;
         // New flag used so slot 0 of a frame follows its own sequence
         if (fcyc_d < CONV_BUDGET) begin
            mux_d = alt_d ? i_slot_alternate_select[4*(fcyc_d/cpc) +: 4]
                          : i_slot_input_select[4*(fcyc_d/cpc) +: 4];
         end
         fstart_d = frame_end;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fcyc_q   <= 4'h0;
         altcnt_q <= 4'h0;
         chop_q   <= 1'b0;
         alt_q    <= 1'b0;
         mux_q    <= 4'h0;
         fstart_q <= 1'b0;
      end else begin
         fcyc_q   <= fcyc_d;
         altcnt_q <= altcnt_d;
         chop_q   <= chop_d;
         alt_q    <= alt_d;
         mux_q    <= mux_d;
         fstart_q <= fstart_d;
      end
   end
   assign o_mux_select  = mux_q;
   assign o_chop        = chop_q;
   assign o_frame_start = fstart_q;

   // Shunt gain of eight by shift
   assign ia_g = i_shunt_a ? CUR_W'(signed'(i_ia)) <<< SHUNT_SHIFT : CUR_W'(signed'(i_ia));
   assign ib_g = i_shunt_b ? CUR_W'(signed'(i_ib)) <<< SHUNT_SHIFT : CUR_W'(signed'(i_ib));

   always_comb begin
      v1 = signed'(i_va);
      i0 = ia_g;
      i1 = ib_g;
      case (i_meter_equation_select)
         EQU_SPLIT: begin
            i0 = ia_g - ib_g;
            e0 = ACC_W'((signed'(i_va) * i0) >>> 1);
            e1 = ACC_W'((signed'(i_va) * i1) >>> 1);
         end
         EQU_TWO_ELEM: begin
            v1 = signed'(i_vb);
            e0 = ACC_W'(signed'(i_va) * i0);
            e1 = ACC_W'(v1 * i1);
         end
         default: begin
            e0 = ACC_W'(signed'(i_va) * i0);
            e1 = ACC_W'(v1 * i1);
         end
      endcase
      q0 = ACC_W'(i0 * i0);
      q1 = ACC_W'(i1 * i1);
   end

   // Variant flag; select 0 differs from 1 and 2
   assign o_code_variant = i_meter_equation_select != EQU_TWO_WIRE;

   always_comb begin
      case (i_presample_multiplier)
         2'h0:    pre_mult = PRE_MULT0;
         2'h1:    pre_mult = PRE_MULT1;
         2'h2:    pre_mult = PRE_MULT2;
         default: pre_mult = PRE_MULT3;
      endcase
   end
   assign accumulation_count = ACCUMULATION_COUNT_W'(pre_mult * i_accumulation_cycle_count);

   // Undervoltage magnitude of VA against the threshold word
   assign va_mag = i_va[SAMPLE_W-1] ? SAMPLE_W'(-signed'(i_va)) : i_va;

   // Accumulation, one sample set per frame
   always_comb begin
      ncnt_d = ncnt_q;
      done_d = 1'b0;
      sag_d  = sag_q;
      for (int k = 0; k < 4; k++) begin
         acc_d[k] = acc_q[k];
         res_d[k] = res_q[k];
      end
      // Idle while the enable is low
      if (!i_engine_enable) begin
         ncnt_d = '0;
         for (int k = 0; k < 4; k++) acc_d[k] = '0;
      end else if (frame_end && accumulation_count != '0) begin
         // Threshold in sample LSBs of full scale
         sag_d    = va_mag < mem_q[UNDERVOLTAGE_THRESHOLD_WORD][SAMPLE_W-1:0];
         acc_d[0] = acc_q[0] + e0;
         acc_d[1] = acc_q[1] + e1;
         acc_d[2] = acc_q[2] + q0;
         acc_d[3] = acc_q[3] + q1;
         ncnt_d   = ncnt_q + ACCUMULATION_COUNT_W'(1);
         // Pass closes after the accumulation count
         if (ncnt_d >= accumulation_count) begin
            ncnt_d = '0;
            done_d = 1'b1;
            for (int k = 0; k < 4; k++) begin
               res_d[k] = acc_d[k][ACC_LSB +: WORD_W];
               acc_d[k] = '0;
            end
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ncnt_q <= '0;
         done_q <= 1'b0;
         sag_q  <= 1'b0;
         for (int k = 0; k < 4; k++) begin
            acc_q[k] <= '0;
            res_q[k] <= '0;
         end
      end else begin
         ncnt_q <= ncnt_d;
         done_q <= done_d;
         sag_q  <= sag_d;
         for (int k = 0; k < 4; k++) begin
            acc_q[k] <= acc_d[k];
            res_q[k] <= res_d[k];
         end
      end
   end
   assign o_pass_done = done_q;
   assign o_sag       = sag_q;
endmodule
`default_nettype wire

// ===== tb/mcei_checker.sv
/* Port timing checker for mcei_engine.
   Assumes it is bound to the engine and sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
module mcei_checker (
   // Watched ports
   input wire logic       i_clock,
   input wire logic       i_rst_b,
   input wire logic       i_rd,
   input wire logic       i_engine_enable,
   input wire logic [2:0] i_meter_equation_select,
   input wire logic [1:0] i_chop_control,
   input wire logic       i_tick_32k,
   input wire logic [7:0] o_rdata,
   input wire logic [3:0] o_mux_select,
   input wire logic       o_chop,
   input wire logic       o_frame_start,
   input wire logic       o_code_variant,
   input wire logic       o_pass_done
);
   // One clock domain, so one default
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_b);

   logic [3:0] tcnt_q;
   // Mirror of the frame cycle, counted from the ticks alone
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tcnt_q <= 4'h0;
      end else if (i_tick_32k) begin
         tcnt_q <= (tcnt_q == 4'hc) ? 4'h0 : tcnt_q + 4'h1;
      end
   end

   rd_quiet_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read byte without a read");
   code_variant_a: assert property (o_code_variant == (i_meter_equation_select != 3'h0))
      else $error("code variant wrong for equation");
   frame_pulse_a: assert property (o_frame_start |-> $past(i_tick_32k) ##1 !o_frame_start)
      else $error("frame start not a tick pulse");
   frame_end_a: assert property (i_tick_32k && tcnt_q == 4'hb |=> $stable(o_mux_select))
      else $error("select moved on settling tick");
   frame_start_a: assert property (i_tick_32k && tcnt_q == 4'hc |=> o_frame_start)
      else $error("no frame start after thirteenth tick");
   mux_hold_a: assert property (!$past(i_tick_32k) |-> $stable(o_mux_select))
      else $error("select moved without tick");
   pass_pulse_a: assert property (o_pass_done |=> !o_pass_done)
      else $error("pass done longer than one cycle");
   idle_pass_a: assert property (!i_engine_enable [*2] |-> !o_pass_done)
      else $error("pass done while disabled");
   // Auto chop flips at every frame boundary
   chop_toggle_a: assert property (o_frame_start && i_chop_control == 2'h0 &&
      $past(i_chop_control) == 2'h0 |-> o_chop != $past(o_chop))
      else $error("chop did not toggle");
endmodule
bind mcei_engine mcei_checker u_mcei_checker (.i_clock, .i_rst_b, .i_rd, .i_engine_enable,
   .i_meter_equation_select, .i_chop_control, .i_tick_32k, .o_rdata, .o_mux_select,
   .o_chop, .o_frame_start, .o_code_variant, .o_pass_done);
`default_nettype wire

// ===== tb/mcei_adc_model.sv
/* Converter front end model: time base tick and held samples.
   Assumes levels change only while the engine is disabled. */
`timescale 1ns/100ps
`default_nettype none
module mcei_adc_model #(
   parameter int PERIOD = 4
) (
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_rst_b,
   // Levels to present
   input  wire logic [63:0] i_level,
   // Converter outputs
   output logic             o_tick,
   output logic [63:0]      o_sample
);
   int cnt_q;
   // Tick once per PERIOD clocks, quiet in reset
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q  <= 0;
         o_tick <= 1'b0;
      end else begin
         cnt_q  <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
         o_tick <= (cnt_q == PERIOD - 1);
      end
   end
   // Held level, steady over the frame end
   assign o_sample = i_level;
endmodule
`default_nettype wire

// ===== tb/mcei_engine_tb.sv
/* Bench for mcei_engine: byte map, refused writes, element mapping,
   shunt gain and pass timing. Assumes a 4-clock tick from the model. */
`timescale 1ns/100ps
`default_nettype none
module mcei_engine_tb;
   import mcei_pkg::*;
   logic        clk, rst_b, wr, rd, en, sa, sb, rd_q, armed, tick, chop, fstart, variant, pdone;
   logic [7:0]  addr, wdata, rdata;
   logic        sag;
   logic [2:0]  equ;
   logic [1:0]  pre, chopc;
   logic [3:0]  mux, mux_exp;
   logic [3:0]  tk      = 4'h0;
   logic        altf    = 1'b0;
   logic        mux_chk = 1'b0;
   logic [63:0] level, smp;
   logic [7:0]  exp_q[$];
   int          failures, total_checks, seed, pgap, exp_gap;
   int          gap = -1000000;
   int          fr  = 0;
   int          mul[4] = '{42, 50, 84, 100};
   // slot and alternate slot selects, slot 0 in the low nibble
   localparam logic [15:0] SLOTS = 16'h3210;
   localparam logic [15:0] ALTS  = 16'h3b1a;

   mcei_adc_model #(.PERIOD(4)) u_mcei_adc_model (.i_clock(clk), .i_rst_b(rst_b),
      .i_level(level), .o_tick(tick), .o_sample(smp));
   mcei_engine u_mcei_engine (.i_clock(clk), .i_rst_b(rst_b), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_engine_enable(en),
      .i_meter_equation_select(equ), .i_presample_multiplier(pre),
      // four conversions per frame; one cycle count keeps passes short
      .i_accumulation_cycle_count(6'h01), .i_conversions_per_frame(4'h4),
      .i_slot_input_select(SLOTS), .i_slot_alternate_select(ALTS),
      .i_chop_control(chopc), .i_shunt_a(sa), .i_shunt_b(sb), .i_tick_32k(tick),
      .i_va(smp[63:48]), .i_vb(smp[47:32]), .i_ia(smp[31:16]), .i_ib(smp[15:0]),
      .o_mux_select(mux), .o_chop(chop), .o_frame_start(fstart),
      .o_code_variant(variant), .o_pass_done(pdone), .o_sag(sag));

   always #5 clk = ~clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want) begin
         failures++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, want);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Word goes out most significant byte first
   task automatic wr_word(input logic [5:0] w, input logic [31:0] d);
      for (int k = 0; k < 4; k++) begin
         addr  <= {w, 2'(k)};
         wdata <= d[31-8*k -: 8];
         wr    <= 1'b1;
         @(posedge clk);
      end
      wr <= 1'b0;
   endtask

   // Back-to-back byte reads, expectations queued
   task automatic rd_word(input logic [5:0] w, input logic [31:0] d);
      for (int k = 0; k < 4; k++) begin
         addr <= {w, 2'(k)};
         rd   <= 1'b1;
         exp_q.push_back(d[31-8*k -: 8]);
         @(posedge clk);
      end
      rd <= 1'b0;
   endtask

   // Pulse seen between edges, so no edge race
   task automatic wait_pass();
      int n;
      n = 0;
      @(negedge clk);
      while (pdone !== 1'b1 && n < 6000) begin
         @(negedge clk);
         n++;
      end
      check(32'(n < 6000), 32'h1);
      @(posedge clk);
   endtask

   function automatic logic [31:0] res(input longint p, input int f);
      longint s;
      s = p * f;
      return s[47:16];
   endfunction

   // Expected select for frame cycle c; three cycles per conversion at four per frame
   function automatic logic [3:0] slot_of(input logic a, input int c);
      logic [15:0] s;
      s = a ? ALTS : SLOTS;
      return s[4*(c/3) +: 4];
   endfunction

   // Monitor: read bytes, frame and pass spacing
   always @(posedge clk) begin
      rd_q <= rd;
      gap  <= gap + 1;
      pgap <= pgap + 1;
      if (rd_q)
         check(rdata, exp_q.pop_front());
      if (fstart === 1'b1) begin
         if (gap > 0)
            check(gap, 52);
         gap <= 1;
      end
      if (pdone === 1'b1) begin
         if (armed)
            check(pgap, exp_gap);
         armed <= 1'b1;
         pgap  <= 1;
      end
      // First pass after an enable only arms the spacing check
      if (en !== 1'b1)
         armed <= 1'b0;
      mux_chk <= 1'b0;
      if (mux_chk)
         check(mux, mux_exp);
      // alternate frame after every sixteenth frame end in auto chop
      if (tick === 1'b1) begin
         if (tk == 4'hc) begin
            tk      <= 4'h0;
            fr      <= fr + 1;
            altf    <= chopc == 2'h0 && (fr + 1) % 16 == 0;
            mux_exp <= slot_of(chopc == 2'h0 && (fr + 1) % 16 == 0, 0);
            mux_chk <= 1'b1;
         end else begin
            tk <= tk + 4'h1;
            if (tk < 4'hb) begin
               mux_exp <= slot_of(altf, int'(tk) + 1);
               mux_chk <= 1'b1;
            end
         end
      end
   end

   // Hang guard, well past the expected run
   initial begin
      #1000000;
      failures++;
      print_verdict();
   end

   initial begin
      logic signed [15:0] va, vb, ia, ib;
      longint             ga, gb, w0, w1, q0, q1;
      logic [31:0]        d;
      logic [5:0]         ws[3];
      ws = '{6'h00, 6'h15, 6'h3f};
      {clk, rst_b, wr, rd, en, sa, sb} = '0;
      {addr, wdata, equ, pre, chopc, level} = '0;
      seed = 98;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 3; i++) begin
         d = $random(seed);
         wr_word(ws[i], d);
         rd_word(ws[i], d);
      end
      $display("test byte map done");
      for (int i = 0; i < 4; i++) begin
         va = 16'($random(seed)) & 16'hfffe;
         vb = 16'($random(seed));
         ia = 16'($random(seed));
         ib = 16'($random(seed));
         en <= 1'b0;
         // equation and presample set while disabled
         equ   <= 3'(i % 3);
         pre   <= 2'(i);
         sa    <= i[0];
         sb    <= i[1];
         chopc <= (i == 3) ? 2'h2 : 2'h0; // Last pass tries the fixed chop level
         level <= {va, vb, ia, ib};
         // threshold loaded before enable; full threshold forces a sag
         wr_word(UNDERVOLTAGE_THRESHOLD_WORD, (i == 2) ? 32'h0000ffff : 32'h0);
         exp_gap = mul[i] * 52;
         // pass-complete pulse watched from here on
         en <= 1'b1;
         ga = longint'(ia) * (i[0] ? 8 : 1);
         gb = longint'(ib) * (i[1] ? 8 : 1);
         w0 = (i % 3 == 1) ? (longint'(va) * (ga - gb)) >>> 1 : longint'(va) * ga;
         w1 = (i % 3 == 1) ? (longint'(va) * gb) >>> 1 :
              (i % 3 == 2) ? longint'(vb) * gb : longint'(va) * gb;
         // Squared currents follow the same element currents
         q0 = (i % 3 == 1) ? (ga - gb) * (ga - gb) : ga * ga;
         q1 = gb * gb;
         wait_pass();
         check(sag, 32'(i == 2));
         if (i == 3)
            check(chop, 32'h1);
         // Result words ignore host writes
         wr_word(W0_WORD, ~res(w0, mul[i]));
         rd_word(W0_WORD, res(w0, mul[i]));
         rd_word(W1_WORD, res(w1, mul[i]));
         rd_word(I0SQ_WORD, res(q0, mul[i]));
         rd_word(I1SQ_WORD, res(q1, mul[i]));
         rd_word(STATUS_WORD, 32'(i == 2) << STATUS_SAG_BIT);
         wait_pass();
         $display("test pass %0d done", i);
      end
      print_verdict();
   end
endmodule
`default_nettype wire
